// file: include/prt_pkg.sv
`default_nettype none
package prt_pkg;
    localparam logic [7:0] PRT_ADDR_COUNTER   = 8'hAC;
    localparam logic [7:0] PRT_ADDR_RELOAD    = 8'hAD;
    localparam logic [7:0] PRT_ADDR_CONTROL   = 8'hAE;
    localparam logic [7:0] PRT_COUNTER_RESET  = 8'hFF;
    localparam logic [7:0] PRT_RELOAD_RESET   = 8'h00;
    localparam logic [7:0] PRT_CONTROL_RESET  = 8'h00;
    localparam int         PRT_BIT_TOGGLE     = 5;
    localparam int         PRT_BIT_RUN        = 4;
    localparam int         PRT_BIT_PENDING    = 3;
    localparam int         PRT_BIT_IRQ_EN     = 2;
    localparam int         PRT_PSC_LSB        = 0;
    localparam logic [7:0] PRT_CONTROL_MASK   = 8'h3F;
    localparam int         PRT_PSC_WIDTH      = 3;
endpackage : prt_pkg
`default_nettype wire

// file: include/prt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prt_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       global_irq_en;
    logic       port_value;
    logic       timer_irq;
    logic       pwm_out;
    logic       shared_pin;
    modport device (
        input  addr, wdata, wr, rd, global_irq_en, port_value,
        output rdata, timer_irq, pwm_out, shared_pin
    );
    modport core (
        output addr, wdata, wr, rd, global_irq_en, port_value,
        input  rdata, timer_irq, pwm_out, shared_pin
    );
endinterface : prt_if
`default_nettype wire

// file: hw/prt_timer.sv
// What this block does
// - Run bit stops or starts counting
// - Counter decrements once per prescaled tick
// - Prescale select divides by 1,2,4,8
// - Step from 0x00 is an underflow
// - Underflow reloads counter from reload value
// - Underflow sets the pending flag
// - Toggle enable inverts output on underflow
// - Interrupt needs enable and global enable
// - Interrupt raised when pending flag sets
// - Toggling output edges coincide with interrupts
// - Reset counter 0xFF, reload 0x00
// - Counter, reload, control are readable/writable
// - Timer output drives shared pin
// - Output starts from port data bit
// - Software sets shared pin as output
// - Software may preload counter first phase
// - Software clears flag, writes alternate reload
// - Service routine manages flag and enable
// - Counter at 0xAC, control at 0xAE
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module prt_timer
    import prt_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    prt_if.device     bus
);
    logic [7:0]               counter_ff;
    logic [7:0]               reload_ff;
    logic                     toggle_en_ff;
    logic                     run_ff;
    logic                     pending_ff;
    logic                     irq_en_ff;
    logic [1:0]               psc_sel_ff;
    logic [PRT_PSC_WIDTH-1:0] psc_ff;
    logic                     pwm_ff;
    logic [7:0]               rdata_ff;
    logic                     tick;
    logic                     step;
    logic                     underflow;
    logic                     wr_cnt;
    logic                     wr_rel;
    logic                     wr_ctl;
    logic [7:0]               control_view;
    logic [7:0]               nxt_counter;
    logic                     nxt_pending;
    logic                     nxt_pwm;
    logic [7:0]               nxt_rdata;

    // The divide by eight tap needs three prescaler bits
    if (PRT_PSC_WIDTH < 3) begin : gen_psc_check
        $error("prescaler narrower than the divide by eight tap");
    end

    assign wr_cnt = bus.wr && (bus.addr == PRT_ADDR_COUNTER);
    assign wr_rel = bus.wr && (bus.addr == PRT_ADDR_RELOAD);
    assign wr_ctl = bus.wr && (bus.addr == PRT_ADDR_CONTROL);

    // Cleared while stopped, so the first phase after a start is exact
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psc_ff <= '0;
        end else if (!run_ff) begin
            psc_ff <= '0;
        end else begin
            psc_ff <= psc_ff + PRT_PSC_WIDTH'(1);
        end
    end

    // Tick when the low prescaler bits chosen by the divider are all ones
    always_comb begin
        unique case (psc_sel_ff)
            2'b00: tick = 1'b1;
            2'b01: tick = psc_ff[0];
            2'b10: tick = &psc_ff[1:0];
            2'b11: tick = &psc_ff[2:0];
        endcase
    end

    assign step      = run_ff && tick;
    assign underflow = step && (counter_ff == 8'h00);

    // A software write loses only to the reload of an underflow in the same cycle
    always_comb begin
        nxt_counter = counter_ff;
        if (underflow) begin
            nxt_counter = reload_ff;
        end else if (wr_cnt) begin
            nxt_counter = bus.wdata;
        end else if (step) begin
            nxt_counter = counter_ff - 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            counter_ff <= PRT_COUNTER_RESET;
        end else begin
            counter_ff <= nxt_counter;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reload_ff <= PRT_RELOAD_RESET;
        end else if (wr_rel) begin
            reload_ff <= bus.wdata;
        end
    end

    // One register per control field; bits 7 and 6 have no storage
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_ff <= PRT_CONTROL_RESET[PRT_BIT_RUN];
        end else if (wr_ctl) begin
            run_ff <= bus.wdata[PRT_BIT_RUN];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle_en_ff <= PRT_CONTROL_RESET[PRT_BIT_TOGGLE];
        end else if (wr_ctl) begin
            toggle_en_ff <= bus.wdata[PRT_BIT_TOGGLE];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_en_ff <= PRT_CONTROL_RESET[PRT_BIT_IRQ_EN];
        end else if (wr_ctl) begin
            irq_en_ff <= bus.wdata[PRT_BIT_IRQ_EN];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psc_sel_ff <= PRT_CONTROL_RESET[PRT_PSC_LSB +: 2];
        end else if (wr_ctl) begin
            psc_sel_ff <= bus.wdata[PRT_PSC_LSB +: 2];
        end
    end

    // Writing one keeps the flag, so a field update never loses a pending event
    always_comb begin
        nxt_pending = pending_ff;
        if (wr_ctl && !bus.wdata[PRT_BIT_PENDING]) begin
            nxt_pending = 1'b0;
        end
        if (underflow) begin
            nxt_pending = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending_ff <= PRT_CONTROL_RESET[PRT_BIT_PENDING];
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // While toggling is off the output tracks the port bit, so it starts from it
    always_comb begin
        nxt_pwm = pwm_ff;
        if (!toggle_en_ff) begin
            nxt_pwm = bus.port_value;
        end else if (underflow) begin
            nxt_pwm = ~pwm_ff;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwm_ff <= 1'b0;
        end else begin
            pwm_ff <= nxt_pwm;
        end
    end

    assign control_view = {2'b00, toggle_en_ff, run_ff, pending_ff, irq_en_ff, psc_sel_ff};

    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                PRT_ADDR_COUNTER: nxt_rdata = counter_ff;
                PRT_ADDR_RELOAD:  nxt_rdata = reload_ff;
                PRT_ADDR_CONTROL: nxt_rdata = control_view;
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus.rdata      = rdata_ff;
    assign bus.pwm_out    = pwm_ff;
    assign bus.shared_pin = toggle_en_ff ? pwm_ff : bus.port_value;
    assign bus.timer_irq  = pending_ff && irq_en_ff && bus.global_irq_en;
endmodule : prt_timer
`default_nettype wire

// file: hw/prt_core_port.sv
`timescale 1ns/1ps
`default_nettype none
module prt_core_port
    import prt_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       global_irq_en_i,
    input  wire logic       port_value_i,
    output logic      [7:0] rdata_o,
    output logic            timer_irq_o,
    output logic            shared_pin_o,
    prt_if.core             bus
);
    // Software side: register strobes pass straight through, one cycle read latency
    assign bus.addr          = addr_i;
    assign bus.wdata         = wdata_i;
    assign bus.wr            = wr_i;
    assign bus.rd            = rd_i;
    assign bus.global_irq_en = global_irq_en_i;
    assign bus.port_value    = port_value_i;
    assign rdata_o           = bus.rdata;
    assign timer_irq_o       = bus.timer_irq;
    assign shared_pin_o      = bus.shared_pin;
endmodule : prt_core_port
`default_nettype wire

// file: verif/prt_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module prt_timer_asserts (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       global_irq_en,
    input wire logic       port_value,
    input wire logic       timer_irq,
    input wire logic       pwm_out,
    input wire logic       shared_pin
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    chk_irq_gate: assert property (timer_irq |-> global_irq_en)
        else $error("irq without global enable");
    chk_pin_mux: assert property (shared_pin == pwm_out || shared_pin == port_value)
        else $error("pin is neither timer nor port");
    chk_rd_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_ctrl_rsvd: assert property (rd && addr == 8'hAE |=> rdata[7:6] == 2'b00)
        else $error("reserved control bits set");
    chk_unmapped_rd: assert property (rd && (addr < 8'hAC || addr > 8'hAE) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reload_back: assert property (wr && addr == 8'hAD ##2 rd && addr == 8'hAD
        |=> rdata == $past(wdata, 3))
        else $error("reload readback wrong");
    // Rising irq with no write or enable change can only come from an underflow
    chk_irq_edge: assert property ($rose(timer_irq) && !$past(wr) && $stable(global_irq_en)
        |-> $changed(pwm_out) || pwm_out == port_value)
        else $error("irq without output edge");
    chk_irq_hold: assert property (timer_irq && !wr |=> timer_irq || !global_irq_en)
        else $error("irq dropped by itself");
    cover property ($rose(timer_irq));
    cover property ($changed(pwm_out));
    cover property (rd && addr == 8'hAE);
endmodule : prt_timer_asserts
`default_nettype wire

// file: verif/prt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module prt_timer_bench;
    import prt_pkg::*;
    logic       clock_i, resetn_i, wr, rd, gie, pv, irq, pin;
    logic [7:0] addr, wdata, rdata;
    int         num_errors = 0, num_checks = 0, cycles = 0;
    prt_if ifc();
    prt_timer prt_timer_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus(ifc.device));
    prt_core_port prt_core_port_inst (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .global_irq_en_i(gie), .port_value_i(pv),
        .rdata_o(rdata), .timer_irq_o(irq), .shared_pin_o(pin), .bus(ifc.core));
    prt_timer_asserts prt_timer_asserts_inst (.clock_i(clock_i), .resetn_i(resetn_i),
        .addr(ifc.addr), .wdata(ifc.wdata), .wr(ifc.wr), .rd(ifc.rd), .rdata(ifc.rdata),
        .global_irq_en(ifc.global_irq_en), .port_value(ifc.port_value),
        .timer_irq(ifc.timer_irq), .pwm_out(ifc.pwm_out), .shared_pin(ifc.shared_pin));
    initial begin
        clock_i = 0;
        forever #25 clock_i = ~clock_i;
    end
    task test_done();
        $display("errors=%0d checks=%0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // Run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= a; rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rreg
    // Prescaler restarts on run, so edge spacing is exact; start level alternates
    task t_pwm(input int p);
        int   n;
        int   d;
        logic s;
        d = 1 << p;
        s = p[0];
        @(posedge clock_i);
        pv <= s;
        wreg(PRT_ADDR_COUNTER, 8'h02);
        wreg(PRT_ADDR_RELOAD, 8'h03);
        chk({7'h0, pin}, {7'h0, s});
        wreg(PRT_ADDR_CONTROL, 8'h30 | 8'(p));
        n = 0;
        while (pin === s && n < 99) begin @(posedge clock_i); #1 n++; end
        chk(8'(n), 8'(3 * d));
        chk({7'h0, pin}, {7'h0, ~s});
        n = 0;
        while (pin === ~s && n < 99) begin @(posedge clock_i); #1 n++; end
        chk(8'(n), 8'(4 * d));
        rreg(PRT_ADDR_CONTROL, 8'h38 | 8'(p));
        chk({7'h0, irq}, 8'h00);
        wreg(PRT_ADDR_CONTROL, 8'h00);
    endtask : t_pwm
    task t_irq();
        int n;
        wreg(PRT_ADDR_COUNTER, 8'h00);
        wreg(PRT_ADDR_RELOAD, 8'h10);
        wreg(PRT_ADDR_CONTROL, 8'h14);
        n = 0;
        while (irq !== 1'b1 && n < 9) begin @(posedge clock_i); #1 n++; end
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, pin}, 8'h01);
        @(posedge clock_i);
        gie <= 1'b0;
        #1 chk({7'h0, irq}, 8'h00);
        @(posedge clock_i);
        gie <= 1'b1;
        wreg(PRT_ADDR_CONTROL, 8'h04);
        #1 chk({7'h0, irq}, 8'h00);
        rreg(PRT_ADDR_CONTROL, 8'h04);
        // Second clearing write lands on the underflow edge, where the set wins
        wreg(PRT_ADDR_COUNTER, 8'h01);
        wreg(PRT_ADDR_CONTROL, 8'h14);
        wreg(PRT_ADDR_CONTROL, 8'h14);
        rreg(PRT_ADDR_CONTROL, 8'h1C);
        chk({7'h0, irq}, 8'h01);
        wreg(PRT_ADDR_CONTROL, 8'h00);
    endtask : t_irq
    task t_regs();
        rreg(PRT_ADDR_COUNTER, 8'hFF);
        rreg(PRT_ADDR_RELOAD, 8'h00);
        rreg(8'h10, 8'h00);
        wreg(PRT_ADDR_CONTROL, 8'hC3);
        rreg(PRT_ADDR_CONTROL, 8'h03);
        wreg(PRT_ADDR_RELOAD, 8'h5A);
        rreg(PRT_ADDR_RELOAD, 8'h5A);
        wreg(PRT_ADDR_COUNTER, 8'hA5);
        rreg(PRT_ADDR_COUNTER, 8'hA5);
    endtask : t_regs
    initial begin
        addr = 8'h00; wdata = 8'h00; wr = 0; rd = 0; gie = 1; pv = 1; resetn_i = 0;
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_regs();
        for (int p = 0; p < 4; p++) t_pwm(p);
        t_irq();
        test_done();
    end
endmodule : prt_timer_bench
`default_nettype wire
